// [pcg_pkg.sv]
package pcg_pkg;

  // Register map
  localparam logic [15:0] PCG_CFG_ADDR = 16'h0058;

  // Reset values chosen by the three strap pins (one, two, three)
  localparam logic [15:0] PCG_RST_S000 = 16'h0000;
  localparam logic [15:0] PCG_RST_S001 = 16'h9007;
  localparam logic [15:0] PCG_RST_S010 = 16'h4007;
  localparam logic [15:0] PCG_RST_S100 = 16'h1007;
  localparam logic [15:0] PCG_RST_S110 = 16'hF007;
  localparam logic [15:0] PCG_RST_S111 = 16'h0000;
  localparam logic [15:0] PCG_RST_S101 = 16'hF000;
  localparam logic [15:0] PCG_RST_S011 = 16'h0000;

  // Multiplier field value with a special meaning
  localparam logic [3:0] PCG_MULT_SPECIAL = 4'hF;

  // Lock timer counts in units of two to this power clock cycles
  localparam int PCG_LOCK_SHIFT = 4;
  // Consecutive matching reference periods that count as lock
  localparam logic [2:0] PCG_LOCK_MATCHES = 3'h4;

  // Clock mode register layout, bit 15 first
  typedef struct packed {
    logic [3:0] mult;     // Ratio field, also /2 or /4 select in divider mode
    logic mult_hi;        // Upper ratio bank
    logic [7:0] lock_cnt; // Lock timer setting
    logic pll_sel;        // One selects PLL mode
    logic pll_on;         // PLL powered
    logic status;         // Read only: master clock runs from PLL
  } pcg_cfg_s;

  typedef enum logic [1:0] {
    PCG_ST_DIV  = 2'b00,
    PCG_ST_ACQ  = 2'b01,
    PCG_ST_WAIT = 2'b10,
    PCG_ST_RUN  = 2'b11
  } pcg_state_e;

endpackage

// [pcg_sync2.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs
module pcg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,               // System clock
  input wire logic srst,              // Synchronous reset
  input wire logic [WIDTH-1:0] din,   // Asynchronous inputs
  output logic [WIDTH-1:0] dout       // Synchronised outputs
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// [pcg_clock_gen.sv]
// Behaviour
// - Divider mode makes the master clock from the reference divided by two or four.
// - PLL mode multiplies the reference frequency by one of thirty-one ratios.
// - A started PLL acquires lock first, then keeps tracking the reference.
// - A lock timer delays the switch onto the PLL output until lock.
// - In divider mode the PLL can be switched fully off to save power.
// - One 16-bit memory-mapped clock mode register at address 0058h.
// - At reset the mode register loads a value set only by three straps.
// - Straps 000 load 0000h: divide by two, PLL and oscillator off.
// - Straps 001 load 9007h: PLL times ten, oscillator on.
// - Straps 010 load 4007h: PLL times five, oscillator on.
// - Straps 100 load 1007h: PLL times two, oscillator on.
// - Straps 110 load F007h: PLL times one, oscillator on.
// - Straps 111 load 0000h: divide by two, PLL off, oscillator on.
// - Straps 101 load F000h: divide by four, PLL off, oscillator on.
// - Straps are sampled while the active-low reset pin is low.
// - After reset software may rewrite the clock mode register.
// - Oscillator enable follows straps always; other settings stay untouched.
`timescale 1ns/1ns
module pcg_clock_gen
  import pcg_pkg::*;
#(
  parameter int PER_W = 16,  // Width of the reference period counter
  parameter int ACC_W = 17   // Width of the synthesis accumulator
) (
  input wire logic clk,                   // System clock, 125 MHz
  input wire logic srst,                  // Synchronous reset, active high
  input wire logic reference_clock_input, // Reference clock pin
  input wire logic reset_n,               // Device reset pin, active low
  input wire logic mode_strap_pin_one,    // Mode strap 1
  input wire logic mode_strap_pin_two,    // Mode strap 2
  input wire logic mode_strap_pin_three,  // Mode strap 3
  input wire logic [15:0] mem_addr,       // Memory-mapped address
  input wire logic mem_wr,                // Write strobe
  input wire logic mem_rd,                // Read strobe
  input wire logic [15:0] mem_wdata,      // Write data
  output logic [15:0] mem_rdata,          // Read data, one cycle later
  output logic master_clk,                // Master clock
  output logic osc_enable,                // Crystal oscillator enable
  output logic crystal_drive_pin,         // Oscillator drive
  output logic pll_power,                 // PLL powered
  output logic pll_locked                 // PLL lock indication
);

  // Pin synchronisers
  logic [4:0] pins_s;
  pcg_sync2 #(.WIDTH(5)) u_sync (
    .clk(clk),
    .srst(srst),
    .din({reference_clock_input, reset_n, mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three}),
    .dout(pins_s)
  );

  wire ref_s = pins_s[4];
  wire rstn_s = pins_s[3];
  wire [2:0] strap_s = pins_s[2:0];

  // Strap pattern to reset value
  function automatic logic [15:0] strap_value(input logic [2:0] s);
    case (s)
      3'b000: strap_value = PCG_RST_S000;
      3'b001: strap_value = PCG_RST_S001;
      3'b010: strap_value = PCG_RST_S010;
      3'b100: strap_value = PCG_RST_S100;
      3'b110: strap_value = PCG_RST_S110;
      3'b111: strap_value = PCG_RST_S111;
      3'b101: strap_value = PCG_RST_S101;
      default: strap_value = PCG_RST_S011; // Bypass unsupported
    endcase
  endfunction

  logic [15:0] cfg_q;
  logic ref_d_q;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] period_q;
  logic [2:0] match_q;
  logic [ACC_W-1:0] acc_q;
  logic pll_clk_q;
  logic div_clk_q;
  logic div_ph_q;
  pcg_state_e state_q;
  pcg_state_e state_d;
  logic [11:0] timer_q;
  logic src_pll_q;
  logic pins_d_q;

  // Register decode
  pcg_cfg_s cfg;
  assign cfg = pcg_cfg_s'(cfg_q);
  wire cfg_hit = (mem_addr == PCG_CFG_ADDR);
  wire cfg_wr = mem_wr & cfg_hit;
  wire cfg_rd = mem_rd & cfg_hit;
  wire [15:0] rd_val = {cfg_q[15:1], src_pll_q};

  // Ratio decode: 1..15, 17..31 and 16, with F meaning one in the low bank and 16 in the upper
  wire mult_sp = (cfg.mult == PCG_MULT_SPECIAL);
  wire [4:0] ratio_lo = mult_sp ? 5'h01 : {1'b0, cfg.mult} + 5'h01;
  wire [4:0] ratio_hi = mult_sp ? 5'h10 : {1'b0, cfg.mult} + 5'h11;
  wire [4:0] ratio = cfg.mult_hi ? ratio_hi : ratio_lo;
  wire div_by4 = mult_sp;

  // Reference edge and period difference
  wire ref_rise = ref_s & ~ref_d_q;
  wire [PER_W-1:0] per_new = per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
  wire [PER_W-1:0] per_diff = (per_new > period_q) ? per_new - period_q : period_q - per_new;
  wire per_match = (per_diff <= {{(PER_W-1){1'b0}}, 1'b1});
  wire locked = (match_q == PCG_LOCK_MATCHES);

  // Synthesis accumulator step
  wire [ACC_W-1:0] inc = ACC_W'({ratio, 1'b0});
  wire [ACC_W-1:0] sum = acc_q + inc;
  wire [ACC_W-1:0] per_ext = ACC_W'(period_q);
  wire nco_wrap = (sum >= per_ext);

  // Lock timer target and mode wishes
  wire [11:0] lock_wait = {cfg.lock_cnt, PCG_LOCK_SHIFT'(0)};
  wire want_pll = cfg.pll_sel & cfg.pll_on;
  wire use_pll = (state_q == PCG_ST_RUN);

  // Glitch-free source selection
  wire cur_val = src_pll_q ? pll_clk_q : div_clk_q;
  wire new_val = use_pll ? pll_clk_q : div_clk_q;
  wire sw_pend = (use_pll != src_pll_q);
  wire sw_now = sw_pend & ~master_clk & ~new_val;

  // Mode register: strap load while reset pin low, else software writes
  always_ff @(posedge clk)
  begin
    if (srst)
      cfg_q <= '0;
    else if (!rstn_s)
      cfg_q <= strap_value(strap_s);
    else if (cfg_wr)
      cfg_q <= {mem_wdata[15:1], 1'b0};
  end

  // Read port
  always_ff @(posedge clk)
  begin
    if (srst)
      mem_rdata <= '0;
    else
      mem_rdata <= cfg_rd ? rd_val : 16'h0000;
  end

  // Oscillator follows straps regardless of reset pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      osc_enable <= 1'b0;
      crystal_drive_pin <= 1'b0;
    end
    else
    begin
      osc_enable <= (strap_s != 3'b000);
      crystal_drive_pin <= (strap_s != 3'b000) & ~ref_s;
    end
  end

  // Reference period measurement and lock detection
  always_ff @(posedge clk)
  begin
    if (srst || !cfg.pll_on)
    begin
      ref_d_q <= 1'b0;
      per_cnt_q <= '0;
      period_q <= '0;
      match_q <= '0;
    end
    else
    begin
      ref_d_q <= ref_s;
      if (ref_rise)
      begin
        per_cnt_q <= '0;
        period_q <= per_new; // Tracks the reference
        if (!per_match)
          match_q <= '0;
        else if (!locked)
          match_q <= match_q + 3'h1;
      end
      else if (per_cnt_q != '1)
        per_cnt_q <= per_new;
    end
  end

  // Frequency synthesis: output toggles ratio*2 times per reference period
  always_ff @(posedge clk)
  begin
    if (srst || !cfg.pll_on || !locked)
    begin
      acc_q <= '0;
      pll_clk_q <= 1'b0;
    end
    else if (nco_wrap)
    begin
      acc_q <= sum - per_ext;
      pll_clk_q <= ~pll_clk_q;
    end
    else
      acc_q <= sum;
  end

  // Divider: toggle every edge for /2, every second edge for /4
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_clk_q <= 1'b0;
      div_ph_q <= 1'b0;
    end
    else
    begin
      if (ref_s & ~pins_d_q)
      begin
        div_ph_q <= ~div_ph_q;
        if (!div_by4 || div_ph_q)
          div_clk_q <= ~div_clk_q;
      end
    end
  end

  // Own edge history for the divider, valid while the PLL is off
  always_ff @(posedge clk)
  begin
    if (srst)
      pins_d_q <= 1'b0;
    else
      pins_d_q <= ref_s;
  end

  // Mode sequencer: divider, acquire, lock timer, PLL
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PCG_ST_DIV:
        if (want_pll)
          state_d = PCG_ST_ACQ;
      PCG_ST_ACQ:
        if (!want_pll)
          state_d = PCG_ST_DIV;
        else if (locked)
          state_d = PCG_ST_WAIT;
      PCG_ST_WAIT:
        if (!want_pll)
          state_d = PCG_ST_DIV;
        else if (locked && timer_q >= lock_wait)
          state_d = PCG_ST_RUN;
      PCG_ST_RUN:
        if (!want_pll)
          state_d = PCG_ST_DIV;
      default:
        state_d = PCG_ST_DIV;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= PCG_ST_DIV;
      timer_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == PCG_ST_DIV)
        timer_q <= '0;
      else if (timer_q != '1)
        timer_q <= timer_q + 12'h001;
    end
  end

  // Master clock mux, switching only while the output and the new source are low
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      src_pll_q <= 1'b0;
      master_clk <= 1'b0;
    end
    else if (sw_now)
    begin
      src_pll_q <= use_pll;
      master_clk <= 1'b0;
    end
    else if (sw_pend && !master_clk)
      master_clk <= 1'b0;
    else
      master_clk <= cur_val;
  end

  // PLL power and lock outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pll_power <= 1'b0;
      pll_locked <= 1'b0;
    end
    else
    begin
      pll_power <= cfg.pll_on;
      pll_locked <= locked;
    end
  end

  // Checks
  sequence s_enable;
    state_q == PCG_ST_DIV && want_pll;
  endsequence

  sequence s_acquire;
    state_q == PCG_ST_ACQ;
  endsequence

  property p_strap(logic [2:0] pat, logic [15:0] val);
    @(posedge clk) disable iff (srst)
      (!rstn_s && strap_s == pat) |=> cfg_q == val;
  endproperty

  a_strap_000: assert property (p_strap(3'b000, 16'h0000)) else $error("strap 000 value");
  a_strap_001: assert property (p_strap(3'b001, 16'h9007)) else $error("strap 001 value");
  a_strap_010: assert property (p_strap(3'b010, 16'h4007)) else $error("strap 010 value");
  a_strap_100: assert property (p_strap(3'b100, 16'h1007)) else $error("strap 100 value");
  a_strap_110: assert property (p_strap(3'b110, 16'hF007)) else $error("strap 110 value");
  a_strap_111: assert property (p_strap(3'b111, 16'h0000)) else $error("strap 111 value");
  a_strap_101: assert property (p_strap(3'b101, 16'hF000)) else $error("strap 101 value");

  a_strap_hold: assert property (@(posedge clk) disable iff (srst)
    (rstn_s && !cfg_wr) |=> $stable(cfg_q)) else $error("mode register changed without write");

  a_osc_follow: assert property (@(posedge clk) disable iff (srst)
    ##1 osc_enable == ($past(strap_s) != 3'b000)) else $error("oscillator not following straps");

  a_write_take: assert property (@(posedge clk) disable iff (srst)
    (rstn_s && cfg_wr) |=> cfg_q[15:1] == $past(mem_wdata[15:1])) else $error("write not taken");

  a_read_back: assert property (@(posedge clk) disable iff (srst)
    cfg_rd |=> mem_rdata == {$past(cfg_q[15:1]), $past(src_pll_q)}) else $error("read data wrong");

  a_ratio_range: assert property (@(posedge clk) disable iff (srst)
    ratio >= 5'd1 && ratio <= 5'd31) else $error("ratio out of range");

  a_pll_off: assert property (@(posedge clk) disable iff (srst)
    !cfg.pll_on |=> !pll_power && state_q != PCG_ST_RUN ##1 !pll_locked) else $error("PLL not off");

  a_acq_seq: assert property (@(posedge clk) disable iff (srst)
    s_enable ##1 s_acquire |-> !src_pll_q) else $error("PLL used during acquisition");

  a_lock_gate: assert property (@(posedge clk) disable iff (srst)
    (state_q == PCG_ST_WAIT && state_d == PCG_ST_RUN) |-> locked && timer_q >= lock_wait)
    else $error("PLL selected before lock");

  a_div_toggle: assert property (@(posedge clk) disable iff (srst)
    $changed(div_clk_q) |-> $past(ref_s) && !$past(pins_d_q)) else $error("divider moved off edge");

  a_glitch_free: assert property (@(posedge clk) disable iff (srst)
    $changed(src_pll_q) |-> !master_clk && !$past(master_clk)) else $error("switch during high phase");

endmodule

// [pcg_ref_model.sv]
`timescale 1ns/1ns
// Free-running reference source, unrelated in phase to the system clock
module pcg_ref_model (
  input wire logic run,            // Oscillate while high, stand still when low
  input wire logic [15:0] half_ns, // Half period in ns
  output logic ref_out             // Reference clock to the pin
);
  // Toggle every half period; a stopped source holds its level
  initial
  begin
    ref_out = 1'b0;
    #3;
    forever
    begin
      #(half_ns);
      if (run)
        ref_out = ~ref_out;
    end
  end
endmodule

// [pcg_clock_gen_tb.sv]
`timescale 1ns/1ns
module pcg_clock_gen_tb;
  import pcg_pkg::*;
  logic clk, srst, ref_run, reset_n, mem_wr, mem_rd;
  logic mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, half_ns;
  logic reference_clock_input, master_clk, osc_enable, crystal_drive_pin, pll_power, pll_locked;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] strap_val[8];
  logic [15:0] w;
  logic hit;
  int error_cnt, n_checks, seed, i;

  pcg_ref_model ref_src (.run(ref_run), .half_ns(half_ns), .ref_out(reference_clock_input));

  pcg_clock_gen uut (.clk(clk), .srst(srst), .reference_clock_input(reference_clock_input),
    .reset_n(reset_n), .mode_strap_pin_one(mode_strap_pin_one), .mode_strap_pin_two(mode_strap_pin_two),
    .mode_strap_pin_three(mode_strap_pin_three), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .master_clk(master_clk), .osc_enable(osc_enable),
    .crystal_drive_pin(crystal_drive_pin), .pll_power(pll_power), .pll_locked(pll_locked));

  // 125 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare one value and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(posedge clk);
    #1;
    mem_wr = 1'b0;
  endtask

  // One-cycle read strobe; expectation goes to the queue
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk);
    #1;
    mem_addr = a;
    mem_rd = 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    #1;
    mem_rd = 1'b0;
  endtask

  // Four master clock periods in system cycles, bounded
  task automatic period(input int exp);
    int n;
    int k;
    int t;
    logic prev;
    n = 0;
    k = 0;
    t = 0;
    prev = master_clk;
    while (k < 5 && t < 4000)
    begin
      @(posedge clk);
      #2;
      t++;
      if (master_clk && !prev)
        k++;
      if (k > 0)
        n++;
      prev = master_clk;
    end
    if (t >= 4000)
    begin
      error_cnt++;
      end_sim();
    end
    else
      chk(16'(n - 1), 16'(4 * exp));
  endtask

  // Read data stands in the cycle after the strobe edge; take the oldest note
  always @(posedge clk)
  begin
    hit = mem_rd;
    #2;
    if (hit)
      chk(mem_rdata & msk_q.pop_front(), exp_q.pop_front());
  end

  // Main sequence
  initial
  begin
    seed = 84;
    error_cnt = 0;
    n_checks = 0;
    srst = 1'b1;
    ref_run = 1'b1;
    half_ns = 16'h00A0;
    reset_n = 1'b0;
    {mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three} = 3'h0;
    mem_addr = 16'h0000;
    mem_wdata = 16'h0000;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    strap_val = '{16'h0000, 16'h9007, 16'h4007, 16'h0000, 16'h1007, 16'hF000, 16'hF007, 16'h0000};
    cyc(20);
    srst = 1'b0;
    // Every strap pattern while the reset pin is low
    for (i = 0; i < 8; i++)
    begin
      {mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three} = 3'(i);
      cyc(8);
      rd(16'h0058, strap_val[i], 16'hFFFE);
      chk(16'(osc_enable), 16'(i != 0));
    end
    $display("test straps done");
    reset_n = 1'b1;
    cyc(6);
    rd(16'h0058, 16'h0000, 16'hFFFF);
    period(80);
    // Unmapped address and random software writes in divider mode
    wr(16'h0060, 16'(($random(seed)) | 16'h0006));
    rd(16'h0060, 16'h0000, 16'hFFFF);
    rd(16'h0058, 16'h0000, 16'hFFFF);
    repeat (4)
    begin
      w = 16'($random(seed)) & 16'hFFF8;
      wr(16'h0058, w);
      rd(16'h0058, w, 16'hFFFF);
      chk(16'(pll_power), 16'h0000);
    end
    wr(16'h0058, 16'hF000);
    period(160);
    $display("test divider done");
    // PLL times ten with lock timer of 20 units
    wr(16'h0058, 16'h90A6);
    cyc(3);
    chk(16'(pll_power), 16'h0001);
    cyc(300);
    chk(16'(pll_locked), 16'h0001);
    rd(16'h0058, 16'h90A6, 16'hFFFF);
    cyc(200);
    rd(16'h0058, 16'h90A7, 16'hFFFF);
    period(4);
    wr(16'h0058, 16'h4006);
    cyc(200);
    period(8);
    $display("test pll done");
    // Strap change after reset touches only the oscillator enable and drive
    {mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three} = 3'h0;
    cyc(6);
    chk(16'(osc_enable), 16'h0000);
    chk(16'(crystal_drive_pin), 16'h0000);
    rd(16'h0058, 16'h4007, 16'hFFFF);
    {mode_strap_pin_one, mode_strap_pin_two, mode_strap_pin_three} = 3'h7;
    cyc(6);
    chk(16'(osc_enable), 16'h0001);
    // Back to divider mode with the PLL off
    wr(16'h0058, 16'h0000);
    cyc(400);
    chk(16'(pll_power), 16'h0000);
    rd(16'h0058, 16'h0000, 16'hFFFF);
    period(80);
    $display("test straps after reset done");
    cyc(4);
    end_sim();
  end
endmodule
